// ==== src/wool_pkg.sv ====
// Constants and field layout of the write-once option latches.
// Assumes a byte-wide register port with 16-bit byte addresses.
package wool_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [15:0] WOOL_ADDR_OPT_TWO = 16'h001E;
  localparam logic [15:0] WOOL_ADDR_OPT_ONE = 16'h001F;

  localparam logic [7:0]  WOOL_RST_OPT_TWO  = 8'h00;
  localparam logic [7:0]  WOOL_RST_OPT_ONE  = 8'h00;
  localparam logic [7:0]  WOOL_RD_UNMAPPED  = 8'h00;

  // ****************************************************************
  // Field positions, option_latch_two
  // ****************************************************************
  localparam int WOOL_B_OSC_RUN_IN_STOP   = 0;
  localparam int WOOL_B_SLOW_CRYSTAL      = 1;
  localparam int WOOL_B_EXT_CLOCK_ENABLE  = 2;
  localparam int WOOL_B_CRYSTAL_ENABLE    = 3;
  localparam logic [7:0] WOOL_MASK_OPT_TWO = 8'h0F;

  // ****************************************************************
  // Field positions, option_latch_one
  // ****************************************************************
  localparam int WOOL_B_WATCHDOG_DISABLE  = 0;
  localparam int WOOL_B_STOP_ENABLE       = 1;
  localparam int WOOL_B_SHORT_RECOVERY    = 2;
  localparam int WOOL_B_VOLTAGE_MODE      = 3;
  localparam int WOOL_B_MON_POWER_DISABLE = 4;
  localparam int WOOL_B_MON_RESET_DISABLE = 5;
  localparam int WOOL_B_MON_STOP_ENABLE   = 6;
  localparam int WOOL_B_WATCHDOG_RATE     = 7;

  // ****************************************************************
  // Cycle counts handed to the clock, stop and watchdog logic
  // ****************************************************************
  localparam logic [12:0] WOOL_STAB_LONG    = 13'h1000; // 4096
  localparam logic [12:0] WOOL_STAB_SHORT   = 13'h0010; // 16
  localparam logic [12:0] WOOL_RECOV_LONG   = 13'h1000; // 4096
  localparam logic [12:0] WOOL_RECOV_SHORT  = 13'h0020; // 32
  localparam logic [17:0] WOOL_WDOG_SHORT   = 18'h01FF0; // 8176
  localparam logic [17:0] WOOL_WDOG_LONG    = 18'h3FFF0; // 262128

  // ****************************************************************
  // Register port carrier
  // ****************************************************************
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } wool_req_t;

endpackage : wool_pkg

// ==== src/wool_option_latches.sv ====
// Two write-once option registers and the option signals they steer.
// Assumes CPU strobes and the power-on reset flag are on sys_clk_i.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module wool_option_latches (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 por_i,
  input  wire wool_pkg::wool_req_t  req_i,
  output logic [7:0]                rdata_o,
  input  wire logic                 stop_mode_i,
  input  wire logic                 stop_opcode_i,
  input  wire logic                 monitor_reset_req_i,
  input  wire logic                 stop_exit_by_monitor_i,
  output logic                      ext_osc_enable_o,
  output logic                      osc1_clock_in_o,
  output logic                      osc2_crystal_o,
  output logic                      monitor_range_crystal_o,
  output logic                      slow_crystal_o,
  output logic [12:0]               stab_div_count_o,
  output logic                      gen_clock_force_low_o,
  output logic [17:0]               watchdog_timeout_o,
  output logic                      watchdog_enable_o,
  output logic                      monitor_active_o,
  output logic                      monitor_reset_o,
  output logic                      monitor_5v_mode_o,
  output logic [12:0]               stop_recovery_o,
  output logic                      stop_execute_o,
  output logic                      stop_illegal_o
);
  import wool_pkg::*;

  // ****************************************************************
  // Latches and write-once tracking
  // ****************************************************************
  logic [7:0] opt_two_q;
  logic [7:0] opt_one_q;
  logic [3:0] opt_one_hi_q;
  logic [2:0] opt_one_lo_q;
  logic       vmode_q;
  logic       two_done_q;
  logic       one_done_q;
  logic       vmode_done_q;
  logic       wr_two;
  logic       wr_one;

  assign wr_two = req_i.wr && (req_i.addr == WOOL_ADDR_OPT_TWO);
  assign wr_one = req_i.wr && (req_i.addr == WOOL_ADDR_OPT_ONE);

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || por_i)
    begin
      opt_two_q  <= WOOL_RST_OPT_TWO;
      two_done_q <= 1'b0;
    end
    else if (wr_two && !two_done_q)
    begin
      opt_two_q  <= req_i.wdata & WOOL_MASK_OPT_TWO;
      two_done_q <= 1'b1;
    end
  end

  // Voltage mode kept out of the ordinary reset path on purpose
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || por_i)
    begin
      opt_one_hi_q <= WOOL_RST_OPT_ONE[7:4];
      opt_one_lo_q <= WOOL_RST_OPT_ONE[2:0];
      one_done_q   <= 1'b0;
    end
    else if (wr_one && !one_done_q)
    begin
      opt_one_hi_q <= req_i.wdata[7:4];
      opt_one_lo_q <= req_i.wdata[2:0];
      one_done_q   <= 1'b1;
    end
  end

  // One driver per latch; the register view is stitched together here
  assign opt_one_q = {opt_one_hi_q, vmode_q, opt_one_lo_q};

  always_ff @(posedge sys_clk_i)
  begin
    if (por_i)
    begin
      vmode_q      <= WOOL_RST_OPT_ONE[WOOL_B_VOLTAGE_MODE];
      vmode_done_q <= 1'b0;
    end
    else if (!rst_i && wr_one && !vmode_done_q)
    begin
      vmode_q      <= req_i.wdata[WOOL_B_VOLTAGE_MODE];
      vmode_done_q <= 1'b1;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  // readable at any time except while rst_i or por_i is high
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || por_i)
      rdata_o <= WOOL_RD_UNMAPPED;
    else if (req_i.rd && req_i.addr == WOOL_ADDR_OPT_TWO)
      rdata_o <= opt_two_q;
    else if (req_i.rd && req_i.addr == WOOL_ADDR_OPT_ONE)
      rdata_o <= opt_one_q;
    else
      rdata_o <= WOOL_RD_UNMAPPED;
  end

  // ****************************************************************
  // Option decode
  // ****************************************************************
  logic xtal_en;
  logic ext_en;
  logic pwr_dis;

  assign xtal_en = opt_two_q[WOOL_B_CRYSTAL_ENABLE];
  assign ext_en  = opt_two_q[WOOL_B_EXT_CLOCK_ENABLE];
  assign pwr_dis = opt_one_q[WOOL_B_MON_POWER_DISABLE];

  assign ext_osc_enable_o = ext_en;
  assign osc1_clock_in_o  = ext_en;
  assign osc2_crystal_o   = ext_en && xtal_en;
  assign monitor_range_crystal_o = xtal_en;
  assign slow_crystal_o = ext_en && opt_two_q[WOOL_B_SLOW_CRYSTAL];
  assign stab_div_count_o = xtal_en ? WOOL_STAB_LONG : WOOL_STAB_SHORT;
  assign gen_clock_force_low_o =
    stop_mode_i && !opt_two_q[WOOL_B_OSC_RUN_IN_STOP];

  assign watchdog_timeout_o = opt_one_q[WOOL_B_WATCHDOG_RATE] ?
                              WOOL_WDOG_SHORT : WOOL_WDOG_LONG;
  assign watchdog_enable_o = !opt_one_q[WOOL_B_WATCHDOG_DISABLE];

  assign monitor_active_o = !pwr_dis &&
    (!stop_mode_i || opt_one_q[WOOL_B_MON_STOP_ENABLE]);
  assign monitor_reset_o = monitor_reset_req_i && monitor_active_o &&
                           !opt_one_q[WOOL_B_MON_RESET_DISABLE];
  assign monitor_5v_mode_o = opt_one_q[WOOL_B_VOLTAGE_MODE];

  // short recovery only when stop is not exited by the monitor
  assign stop_recovery_o =
    (opt_one_q[WOOL_B_SHORT_RECOVERY] && !stop_exit_by_monitor_i) ?
    WOOL_RECOV_SHORT : WOOL_RECOV_LONG;

  assign stop_execute_o = stop_opcode_i && opt_one_q[WOOL_B_STOP_ENABLE];
  assign stop_illegal_o = stop_opcode_i && !opt_one_q[WOOL_B_STOP_ENABLE];

endmodule : wool_option_latches

`default_nettype wire

// ==== sim/wool_option_latches_monitor.sv ====
// Checker for the write-once option latches.
// Assumes one clock domain; both resets are synchronous.
`timescale 1ns/100ps
`default_nettype none
module wool_mon (
  input wire logic                sys_clk_i,
  input wire logic                rst_i,
  input wire logic                por_i,
  input wire wool_pkg::wool_req_t req_i,
  input wire logic [7:0]          rdata_o,
  input wire logic                stop_mode_i,
  input wire logic                stop_opcode_i,
  input wire logic                monitor_reset_req_i,
  input wire logic                stop_exit_by_monitor_i,
  input wire logic                ext_osc_enable_o,
  input wire logic                osc1_clock_in_o,
  input wire logic                osc2_crystal_o,
  input wire logic                monitor_range_crystal_o,
  input wire logic                slow_crystal_o,
  input wire logic [12:0]         stab_div_count_o,
  input wire logic                gen_clock_force_low_o,
  input wire logic [17:0]         watchdog_timeout_o,
  input wire logic                watchdog_enable_o,
  input wire logic                monitor_active_o,
  input wire logic                monitor_reset_o,
  input wire logic                monitor_5v_mode_o,
  input wire logic [12:0]         stop_recovery_o,
  input wire logic                stop_execute_o,
  input wire logic                stop_illegal_o
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i || por_i);
  a_hold_no_write: assert property (!$past(req_i.wr) && !$past(rst_i)
    && !$past(por_i) |-> $stable({watchdog_enable_o, monitor_5v_mode_o,
    ext_osc_enable_o})) else $error("option changed without a write");
  a_rdata_idle: assert property (!$past(req_i.rd) |-> rdata_o == 8'h00)
    else $error("read data outside its slot");
  a_stab_count: assert property (stab_div_count_o ==
    (monitor_range_crystal_o ? 13'h1000 : 13'h0010))
    else $error("stabilization count wrong");
  a_osc2_both: assert property (osc2_crystal_o ==
    (osc1_clock_in_o && monitor_range_crystal_o)) else $error("osc2 wrong");
  a_slow_needs_ext: assert property (
    slow_crystal_o |-> ext_osc_enable_o)
    else $error("slow crystal without external clock");
  a_osc1_ext: assert property (osc1_clock_in_o == ext_osc_enable_o)
    else $error("osc1 not following enable");
  a_force_low_stop: assert property (
    gen_clock_force_low_o |-> stop_mode_i)
    else $error("clocks forced low outside stop");
  a_wdog_period: assert property (watchdog_timeout_o inside
    {18'h01FF0, 18'h3FFF0}) else $error("watchdog period wrong");
  a_mon_reset_cause: assert property (monitor_reset_o |->
    monitor_reset_req_i && monitor_active_o) else $error("stray monitor reset");
  a_long_recov: assert property (stop_exit_by_monitor_i |->
    stop_recovery_o == 13'h1000) else $error("short recovery on monitor exit");
  a_stop_split: assert property (stop_opcode_i |->
    stop_execute_o != stop_illegal_o) else $error("stop decode wrong");
  c_illegal: cover property (stop_illegal_o);
  c_crystal: cover property (osc2_crystal_o);
  c_mon_reset: cover property (monitor_reset_o);
endmodule : wool_mon
bind wool_option_latches wool_mon u_mon (.*);
`default_nettype wire

// ==== sim/wool_option_latches_tb.sv ====
// Self-checking bench for the write-once option latches.
// Assumes the register port answers reads one cycle later.
`timescale 1ns/100ps
`default_nettype none
module write_once_option_latches_tb;
  import wool_pkg::*;
  logic sys_clk_i = 0, rst_i = 1, por_i = 1;
  logic stop_mode_i = 0, stop_opcode_i = 0;
  logic monitor_reset_req_i = 0, stop_exit_by_monitor_i = 0;
  wool_req_t req_i = '0;
  logic [7:0] rdata_o;
  logic [12:0] stab_div_count_o, stop_recovery_o;
  logic [17:0] watchdog_timeout_o;
  logic ext_osc_enable_o, osc1_clock_in_o, osc2_crystal_o, slow_crystal_o;
  logic monitor_range_crystal_o, gen_clock_force_low_o, watchdog_enable_o;
  logic monitor_active_o, monitor_reset_o, monitor_5v_mode_o;
  logic stop_execute_o, stop_illegal_o;
  int error_cnt = 0, n_checks = 0;
  wool_option_latches dut (.sys_clk_i, .rst_i, .por_i, .req_i, .rdata_o,
    .stop_mode_i, .stop_opcode_i, .monitor_reset_req_i,
    .stop_exit_by_monitor_i,
    .ext_osc_enable_o, .osc1_clock_in_o, .osc2_crystal_o,
    .monitor_range_crystal_o, .slow_crystal_o, .stab_div_count_o,
    .gen_clock_force_low_o, .watchdog_timeout_o, .watchdog_enable_o,
    .monitor_active_o, .monitor_reset_o, .monitor_5v_mode_o,
    .stop_recovery_o, .stop_execute_o, .stop_illegal_o);
  always #5 sys_clk_i = ~sys_clk_i;
  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic chk(input logic [17:0] g, input logic [17:0] e);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_i) req_i <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk_i) req_i <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk_i) req_i <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk_i) req_i <= '0;
    #1 chk(rdata_o, e);
  endtask : rd
  task automatic t_reset_vals;
    rd(WOOL_ADDR_OPT_TWO, 8'h00);
    rd(WOOL_ADDR_OPT_ONE, 8'h00);
    chk(watchdog_timeout_o, WOOL_WDOG_LONG);
    chk({stab_div_count_o, watchdog_enable_o},
      {WOOL_STAB_SHORT, 1'b1});
    @(posedge sys_clk_i);
    stop_mode_i <= 1;
    @(posedge sys_clk_i);
    #1 chk({gen_clock_force_low_o, monitor_active_o,
      monitor_range_crystal_o, monitor_5v_mode_o}, 4'h8);
    @(posedge sys_clk_i);
    stop_mode_i <= 0;
  endtask : t_reset_vals
  task automatic t_write_once;
    wr(WOOL_ADDR_OPT_ONE, 8'hFF);
    wr(WOOL_ADDR_OPT_ONE, 8'h00);
    wr(WOOL_ADDR_OPT_TWO, 8'h0F);
    wr(WOOL_ADDR_OPT_TWO, 8'h00);
    rd(WOOL_ADDR_OPT_ONE, 8'hFF);
    rd(WOOL_ADDR_OPT_TWO, 8'h0F);
    rd(16'h0020, WOOL_RD_UNMAPPED);
    chk({osc2_crystal_o, slow_crystal_o,
      watchdog_enable_o}, 3'h6);
    chk({stab_div_count_o, stop_recovery_o},
      {WOOL_STAB_LONG, WOOL_RECOV_SHORT});
    chk({watchdog_timeout_o, monitor_5v_mode_o},
      {WOOL_WDOG_SHORT, 1'b1});
    @(posedge sys_clk_i);
    stop_exit_by_monitor_i <= 1;
    stop_opcode_i <= 1;
    monitor_reset_req_i <= 1;
    @(posedge sys_clk_i);
    #1 chk(stop_recovery_o, WOOL_RECOV_LONG);
    chk({stop_execute_o, stop_illegal_o,
      monitor_reset_o}, 3'h4);
  endtask : t_write_once
  task automatic t_resets;
    @(posedge sys_clk_i) rst_i <= 1;
    @(posedge sys_clk_i) rst_i <= 0;
    rd(WOOL_ADDR_OPT_ONE, 8'h08);
    wr(WOOL_ADDR_OPT_ONE, 8'h22);
    rd(WOOL_ADDR_OPT_ONE, 8'h2A);
    @(posedge sys_clk_i) por_i <= 1;
    @(posedge sys_clk_i) por_i <= 0;
    rd(WOOL_ADDR_OPT_ONE, 8'h00);
    wr(WOOL_ADDR_OPT_TWO, 8'h05);
    wr(WOOL_ADDR_OPT_ONE, 8'h40);
    @(posedge sys_clk_i);
    stop_mode_i <= 1;
    @(posedge sys_clk_i);
    #1 chk({osc1_clock_in_o, osc2_crystal_o,
      gen_clock_force_low_o}, 3'h4);
    chk({monitor_active_o, monitor_reset_o,
      stop_illegal_o}, 3'h7);
  endtask : t_resets
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  initial
  begin
    #20000 error_cnt++;
    conclude();
  end
  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 0; por_i <= 0;
    t_reset_vals();
    t_write_once();
    t_resets();
    conclude();
  end
endmodule : write_once_option_latches_tb
`default_nettype wire
